// file: design/crt_cfg.svh
// Constants of the processor reset and timebase block.
// Assumes a 100 MHz reference clock and an 8-bit register port.
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH
// Clock rates in Hz
`define CRT_REF_HZ 100000000
`define CRT_SYS_HZ 921600
// Power-up hold time and its cycle count
`define CRT_HOLD_MS 150
`define CRT_HOLD_CYC (`CRT_HOLD_MS * (`CRT_REF_HZ / 1000))
// Tick period in microseconds
`define CRT_TICK_US 146000
// Divider chain ratios
`define CRT_DIV_FIRST 24
`define CRT_DIV_B 2
`define CRT_DIV_C 2803
`define CRT_DIV_D 1
`define CRT_DIV_IND 4
// Register port
`define CRT_ADDR_W 2
`define CRT_REG_CTRL 2'h0
`define CRT_REG_STAT 2'h1
`define CRT_REG_TICKS 2'h2
`define CRT_CTRL_SOFT 0
`define CRT_CTRL_RAMOFF 1
`define CRT_CTRL_RST 8'h00
// Memory card address map
`define CRT_NCARDS 3
`define CRT_RAM_BASE 17'h00000
`define CRT_RAM_SIZE 17'h00800
`define CRT_ROM_BASE 17'h05800
`define CRT_ROM_SIZE 17'h03800
`endif

// file: design/crt_divider.sv
// Modulo counter turning an enable stream into a slower enable pulse.
// Assumes en_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module crt_divider #(
  parameter int unsigned RATIO = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic pulse_o
);
  localparam int unsigned W = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [W-1:0] LAST = W'(RATIO - 1);
  logic [W-1:0] cnt_q;

  // Count input pulses, wrap on the last one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (en_i)
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
  end

  // Registered output costs one cycle of latency but keeps the period exact
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pulse_o <= 1'b0;
    else
      pulse_o <= en_i && (cnt_q == LAST);
  end
endmodule
`default_nettype wire

// file: design/crt_pkg.sv
// Types shared by the reset and timebase block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package crt_pkg;
  typedef enum logic [0:0] {
    CRT_HOLD = 1'b0,
    CRT_RUN = 1'b1
  } crt_state_t;
  // Memory card gate lines: write enable, enable, card select
  typedef struct packed {
    logic wen;
    logic en;
    logic cs;
  } crt_gate_t;
endpackage
`default_nettype wire

// file: design/crt_reset_timebase.sv
// Processor reset sequencer, memory card gating and timebase divider.
// Assumes pins are asynchronous and host bus signals share ref_clk_i.
// Notes on behaviour
// - While power-up reset holds, the local RAM chip enable stays inactive.
// - Processor reset is released 150 ms after power-up starts.
// - The reset push button and the low-supply input both assert processor reset.
// - A falling low-voltage detect both disables local RAM and resets the processor.
// - The first timebase stage divides the 0.9216 MHz processor clock by 24.
// - Later stages give a periodic tick of 0.146 s.
// - The tick divided by 4 drives the clock indicator, which flashes while the clock runs.
// - Static switches enable or disable the card write-enable, enable and card-select gates.
// - Address decode lets three cards coexist with 42K program memory and 6K RAM.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "crt_cfg.svh"
module crt_reset_timebase #(
  parameter int unsigned HOLD_CYCLES = `CRT_HOLD_CYC,
  parameter int unsigned DIV_B = `CRT_DIV_B,
  parameter int unsigned DIV_C = `CRT_DIV_C,
  parameter int unsigned DIV_D = `CRT_DIV_D
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic reset_push_n_i,
  input wire logic low_volt_n_i,
  input wire crt_pkg::crt_gate_t dil_sw_i,
  input wire crt_pkg::crt_gate_t gate_req_i,
  input wire logic ram_ce_req_i,
  input wire logic [15:0] addr_i,
  input wire logic [`CRT_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic host_processor_reset_o,
  output logic ram_ce_o,
  output var crt_pkg::crt_gate_t gate_o,
  output logic [`CRT_NCARDS-1:0] rom_sel_o,
  output logic [`CRT_NCARDS-1:0] ram_sel_o,
  output logic tick_o,
  output logic indicator_o
);
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);
  localparam logic [26:0] PH_STEP = 27'(`CRT_SYS_HZ);
  localparam logic [26:0] PH_WRAP = 27'(`CRT_REF_HZ - `CRT_SYS_HZ);
  localparam int unsigned NSTAGE = 5;
  localparam int unsigned RATIOS [0:NSTAGE-1] = '{`CRT_DIV_FIRST, DIV_B, DIV_C, DIV_D, `CRT_DIV_IND};

  // Synchronised pins
  logic push_n_s;
  logic low_volt_n_s;
  crt_pkg::crt_gate_t dil_s;
  logic push_s;
  logic low_s;
  logic restart;

  crt_pkg::crt_state_t state_q;
  logic [31:0] hold_cnt_q;
  logic [7:0] ctrl_q;
  logic soft_q;
  logic [7:0] ticks_q;
  logic [26:0] phase_q;
  logic sys_en_q;
  logic [NSTAGE:0] stage_en;

  // Pins idle inactive: buttons released, supply good, switches open
  crt_sync #(
    .W(5),
    .INIT(5'h18)
  ) u_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({reset_push_n_i, low_volt_n_i, dil_sw_i}),
    .q_o({push_n_s, low_volt_n_s, dil_s})
  );

  assign push_s = !push_n_s;
  assign low_s = !low_volt_n_s;
  // Push button, low supply and soft reset funnel into one restart term; power-up uses rst_i
  assign restart = push_s || low_s || soft_q;

  // Reset sequencer; rst_i is the power-up event
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= crt_pkg::CRT_HOLD;
      hold_cnt_q <= '0;
      host_processor_reset_o <= 1'b1;
    end
    else if (restart)
    begin
      state_q <= crt_pkg::CRT_HOLD;
      hold_cnt_q <= '0;
      host_processor_reset_o <= 1'b1;
    end
    else
    begin
      case (state_q)
        crt_pkg::CRT_HOLD:
        begin
          if (hold_cnt_q == HOLD_LAST)
          begin
            state_q <= crt_pkg::CRT_RUN;
            host_processor_reset_o <= 1'b0;
          end
          else
            hold_cnt_q <= hold_cnt_q + 32'h1;
        end
        crt_pkg::CRT_RUN:
          host_processor_reset_o <= 1'b0;
        default:
        begin
          state_q <= crt_pkg::CRT_HOLD;
          hold_cnt_q <= '0;
          host_processor_reset_o <= 1'b1;
        end
      endcase
    end
  end

  // Local RAM enable: blocked during hold and the moment supply drops
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ram_ce_o <= 1'b0;
    else
      ram_ce_o <= ram_ce_req_i && (state_q == crt_pkg::CRT_RUN) && !restart
        && !ctrl_q[`CRT_CTRL_RAMOFF];
  end

  // Switch gating of card lines; a switch at 0 holds its line off
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      gate_o <= '0;
    else
      gate_o <= crt_pkg::crt_gate_t'(gate_req_i & dil_s);
  end

  // Window test used for both program and RAM decode
  function automatic logic in_win(input logic [15:0] a, input logic [16:0] lo, input logic [16:0] size);
    logic [16:0] ax;
    ax = {1'b0, a};
    in_win = (ax >= lo) && (ax < lo + size);
  endfunction

  // One program window and one RAM window per card
  for (genvar k = 0; k < `CRT_NCARDS; k++)
  begin : g_card
    localparam logic [16:0] ROM_LO = 17'(`CRT_ROM_BASE + k * `CRT_ROM_SIZE);
    localparam logic [16:0] RAM_LO = 17'(`CRT_RAM_BASE + k * `CRT_RAM_SIZE);
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        rom_sel_o[k] <= 1'b0;
        ram_sel_o[k] <= 1'b0;
      end
      else
      begin
        rom_sel_o[k] <= in_win(addr_i, ROM_LO, `CRT_ROM_SIZE);
        ram_sel_o[k] <= in_win(addr_i, RAM_LO, `CRT_RAM_SIZE);
      end
    end
  end

  // Processor clock as an enable; the accumulator keeps the average rate exact
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_q <= '0;
      sys_en_q <= 1'b0;
    end
    else if (phase_q >= PH_WRAP)
    begin
      phase_q <= phase_q - PH_WRAP;
      sys_en_q <= 1'b1;
    end
    else
    begin
      phase_q <= phase_q + PH_STEP;
      sys_en_q <= 1'b0;
    end
  end

  // Divider chain: 24, three tick stages, then 4 for the indicator
  assign stage_en[0] = sys_en_q;
  for (genvar i = 0; i < NSTAGE; i++)
  begin : g_stage
    crt_divider #(
      .RATIO(RATIOS[i])
    ) u_div (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .en_i(stage_en[i]),
      .pulse_o(stage_en[i+1])
    );
  end

  // Tick pulse and indicator flash
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_o <= 1'b0;
      indicator_o <= 1'b0;
      ticks_q <= '0;
    end
    else
    begin
      tick_o <= stage_en[4];
      if (stage_en[5])
        indicator_o <= !indicator_o;
      if (stage_en[4])
        ticks_q <= ticks_q + 8'h1;
    end
  end

  // Control register; the soft reset bit clears itself
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `CRT_CTRL_RST;
      soft_q <= 1'b0;
    end
    else
    begin
      soft_q <= reg_we_i && (reg_addr_i == `CRT_REG_CTRL) && reg_wdata_i[`CRT_CTRL_SOFT];
      if (reg_we_i && (reg_addr_i == `CRT_REG_CTRL))
        ctrl_q <= {6'h00, reg_wdata_i[`CRT_CTRL_RAMOFF], 1'b0};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= '0;
    else if (reg_re_i)
    begin
      case (reg_addr_i)
        `CRT_REG_CTRL: reg_rdata_o <= ctrl_q;
        `CRT_REG_STAT: reg_rdata_o <= {4'h0, indicator_o, push_s, low_s, host_processor_reset_o};
        `CRT_REG_TICKS: reg_rdata_o <= ticks_q;
        default: reg_rdata_o <= '0;
      endcase
    end
    else
      reg_rdata_o <= '0;
  end

  // Checking helpers: enables counted between divider outputs
  logic [7:0] sys_cnt_q;
  logic [7:0] tk_cnt_q;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sys_cnt_q <= '0;
      tk_cnt_q <= '0;
    end
    else
    begin
      if (stage_en[1])
        sys_cnt_q <= {7'h00, sys_en_q};
      else if (sys_en_q)
        sys_cnt_q <= sys_cnt_q + 8'h1;
      if (stage_en[5])
        tk_cnt_q <= {7'h00, stage_en[4]};
      else if (stage_en[4])
        tk_cnt_q <= tk_cnt_q + 8'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_supply_low;
    low_s;
  endsequence
  sequence s_any_restart;
    restart;
  endsequence

  a_ram_off_hold: assert property (state_q == crt_pkg::CRT_HOLD |=> !ram_ce_o)
    else $error("RAM enabled during hold");
  a_release_late: assert property ($fell(host_processor_reset_o) |-> $past(hold_cnt_q) == HOLD_LAST)
    else $error("Reset released before full hold");
  a_push_reset: assert property (push_s |=> host_processor_reset_o && state_q == crt_pkg::CRT_HOLD)
    else $error("Push button did not reset");
  a_low_supply_both: assert property (s_supply_low |=> host_processor_reset_o && !ram_ce_o)
    else $error("Low supply did not reset and block RAM");
  a_first_div: assert property (stage_en[1] |-> sys_cnt_q == 8'(`CRT_DIV_FIRST))
    else $error("First stage ratio wrong");
  a_tick_pulse: assert property (stage_en[4] |=> tick_o ##1 !tick_o)
    else $error("Tick not a single pulse");
  a_ind_div: assert property (stage_en[5] |-> tk_cnt_q == 8'(`CRT_DIV_IND) ##1 indicator_o != $past(indicator_o))
    else $error("Indicator divide wrong");
  // Checked every cycle so that any single open switch is covered, not only all open
  a_dil_gate: assert property (1'b1 |=> (gate_o & ~$past(dil_s)) == 3'h0)
    else $error("Open switch let a gate through");
  a_rom_decode: assert property ({1'b0, addr_i} >= `CRT_ROM_BASE |=> $onehot(rom_sel_o) && ram_sel_o == '0)
    else $error("Program decode not one card");
  a_restart_hold: assert property (s_any_restart |=> hold_cnt_q == '0 ##1 host_processor_reset_o)
    else $error("Restart did not reload hold");
endmodule
`default_nettype wire

// file: design/crt_sync.sv
// Two flip-flop synchroniser for pins.
// Assumes the inputs are slow static or push button levels.
`timescale 1ns/1ps
`default_nettype none
module crt_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: verification/crt_host_model.sv
// Behavioural host processor and memory card bus driving the block.
// Assumes one clock shared with the block; reset input is active high.
`timescale 1ns/1ps
`default_nettype none
module crt_host_model (
  input wire logic clk_i,
  input wire logic cpu_rst_i,
  output logic [15:0] addr_o,
  output var crt_pkg::crt_gate_t gate_o,
  output logic ram_req_o
);
  // Window edges first, then random addresses
  localparam logic [15:0] CORNER [8] = '{16'h5800, 16'h57ff, 16'hffff, 16'h17ff, 16'h1800, 16'h0000, 16'h9000,
    16'h8fff};
  int unsigned idx_q;
  // Outputs stay unknown only until the first edge, which falls inside the bench reset
  // RAM request keeps toggling in reset: a decode glitch is the hazard
  always @(posedge clk_i)
  begin
    ram_req_o <= 1'($urandom());
    gate_o <= 3'($urandom());
    if (cpu_rst_i)
    begin
      addr_o <= 16'hfffe;
      idx_q <= 0;
    end
    else
    begin
      addr_o <= (idx_q < 8) ? CORNER[idx_q] : 16'($urandom());
      idx_q <= idx_q + 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_cpu_reset_and_timebase.sv
// Self-checking bench for the processor reset and timebase block.
// Assumes the host model drives the bus side; hold and divider shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_and_timebase;
  localparam int HOLD = 200;
  localparam int TICK_CYC = 15625;
  logic ref_clk_i, rst_i, reset_push_n_i, low_volt_n_i, ram_ce_req_i, reg_we_i, reg_re_i;
  crt_pkg::crt_gate_t dil_sw_i, gate_req_i, gate_o;
  logic [15:0] addr_i;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic host_processor_reset_o, ram_ce_o, tick_o, indicator_o;
  logic [2:0] rom_sel_o, ram_sel_o, exp_gate;
  logic [5:0] exp_dec;
  logic exp_ce, mon_on, mon_prev, ram_off;
  int num_errors, cmp_count, nt, t0, guard;
  crt_reset_timebase #(.HOLD_CYCLES(HOLD), .DIV_B(2), .DIV_C(3), .DIV_D(1)) u_crt_reset_timebase (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reset_push_n_i(reset_push_n_i), .low_volt_n_i(low_volt_n_i),
    .dil_sw_i(dil_sw_i), .gate_req_i(gate_req_i), .ram_ce_req_i(ram_ce_req_i), .addr_i(addr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .host_processor_reset_o(host_processor_reset_o), .ram_ce_o(ram_ce_o),
    .gate_o(gate_o), .rom_sel_o(rom_sel_o), .ram_sel_o(ram_sel_o), .tick_o(tick_o), .indicator_o(indicator_o));
  crt_host_model u_crt_host_model (.clk_i(ref_clk_i), .cpu_rst_i(host_processor_reset_o), .addr_o(addr_i),
    .gate_o(gate_req_i), .ram_req_o(ram_ce_req_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata_o);
  endtask
  // Counts edges until reset drops; local RAM must stay shut meanwhile
  task automatic wait_release(input int lo, input int hi);
    int n;
    n = 0;
    while (host_processor_reset_o !== 1'b0 && n < hi + 10)
    begin
      @(posedge ref_clk_i);
      #1 n++;
      if (host_processor_reset_o !== 1'b0) chk("ram_ce_held", 1'b0, ram_ce_o);
    end
    chk_rng("hold_cycles", lo, hi, n);
  endtask
  function automatic logic [5:0] dec(input logic [15:0] a);
    logic [5:0] r;
    int lo;
    r = '0;
    for (int k = 0; k < 3; k++)
    begin
      lo = 'h5800 + k * 'h3800;
      r[3+k] = (a >= lo && a < lo + 'h3800);
      r[k] = (a >= k * 'h800 && a < (k + 1) * 'h800);
    end
    return r;
  endfunction
  // Registered outputs follow the inputs seen one cycle earlier
  always @(posedge ref_clk_i)
  begin
    #1;
    if (mon_on && mon_prev)
    begin
      chk("gate", exp_gate, gate_o);
      chk("rom_sel", exp_dec[5:3], rom_sel_o);
      chk("ram_sel", exp_dec[2:0], ram_sel_o);
      chk("ram_ce", exp_ce, ram_ce_o);
    end
    exp_gate = gate_req_i & dil_sw_i;
    exp_dec = dec(addr_i);
    exp_ce = ram_ce_req_i & ~ram_off;
    mon_prev = mon_on;
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk_i);
    num_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    close_out();
  end
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    mon_on = 1'b0;
    mon_prev = 1'b0;
    ram_off = 1'b0;
    rst_i = 1'b1;
    reset_push_n_i = 1'b1;
    low_volt_n_i = 1'b1;
    dil_sw_i = 3'b111;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    void'($urandom(32'h518a5ea6));
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_release(HOLD, HOLD + 2);
    dil_sw_i <= 3'($urandom());
    repeat (5) @(posedge ref_clk_i);
    mon_on = 1'b1;
    // Tick spacing and ticks per indicator flash, bus monitored meanwhile
    nt = 0;
    t0 = 0;
    guard = 0;
    while (indicator_o !== 1'b1 && guard < 70000)
    begin
      @(posedge ref_clk_i);
      #1 guard++;
      if (tick_o === 1'b1)
      begin
        nt++;
        if (nt == 1) t0 = guard;
        if (nt == 2) chk_rng("tick_period", TICK_CYC - 1, TICK_CYC + 1, guard - t0);
      end
    end
    chk("ticks_per_flash", 4, nt);
    mon_on = 1'b0;
    reg_rd(2'h2, nt[7:0]);
    reg_wr(2'h0, 8'h02);
    ram_off = 1'b1;
    reg_rd(2'h0, 8'h02);
    mon_on = 1'b1;
    repeat (40) @(posedge ref_clk_i);
    mon_on = 1'b0;
    reg_wr(2'h0, 8'h00);
    ram_off = 1'b0;
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3, 8'h00);
    reg_rd(2'h0, 8'h00);
    // Button press, then a second press midway through the hold
    @(posedge ref_clk_i);
    reset_push_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("reset_button", 1'b1, host_processor_reset_o);
    reg_rd(2'h1, 8'h0d);
    @(posedge ref_clk_i);
    reset_push_n_i <= 1'b1;
    repeat (HOLD / 2) @(posedge ref_clk_i);
    reset_push_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_push_n_i <= 1'b1;
    wait_release(HOLD + 1, HOLD + 5);
    // Supply drop shuts RAM and resets until a full hold after recovery
    @(posedge ref_clk_i);
    low_volt_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("reset_low_volt", 1'b1, host_processor_reset_o);
    chk("ram_ce_low_volt", 1'b0, ram_ce_o);
    reg_rd(2'h1, 8'h0b);
    @(posedge ref_clk_i);
    low_volt_n_i <= 1'b1;
    wait_release(HOLD + 1, HOLD + 5);
    reg_wr(2'h0, 8'h01);
    @(posedge ref_clk_i);
    #1 chk("reset_soft", 1'b1, host_processor_reset_o);
    reg_rd(2'h0, 8'h00);
    wait_release(HOLD - 4, HOLD + 2);
    close_out();
  end
endmodule
`default_nettype wire
